// >>> rtl/cit_regs.vh
// register offsets, fields, resets and codes for the cascaded interval timer
`ifndef CIT_REGS_VH
`define CIT_REGS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define CIT_CLK_SEL_LOW_ADDR 8'h00
`define CIT_CLK_SEL_HIGH_ADDR 8'h04
`define CIT_LOW_CMP_ADDR 8'h08
`define CIT_HIGH_CMP_ADDR 8'h0C
`define CIT_LOW_MODE_ADDR 8'h10
`define CIT_HIGH_MODE_ADDR 8'h14
`define CIT_LOW_CNT_ADDR 8'h18
`define CIT_HIGH_CNT_ADDR 8'h1C
`define CIT_IRQ_STAT_ADDR 8'h20
`define CIT_IRQ_EN_ADDR 8'h24
`define CIT_IRQ_CLR_ADDR 8'h28

// ****************************************************************
// mode control fields and reset values
// ****************************************************************
`define CIT_MODE_CNT_EN 7
`define CIT_MODE_CASCADE 4
`define CIT_MODE_LVL_SET 3
`define CIT_MODE_LVL_RST 2
`define CIT_MODE_OUT_EN 0
`define CIT_MODE_RST 8'h00
`define CIT_CLK_SEL_RST 3'h0
`define CIT_CMP_RST 8'h00

// ****************************************************************
// interrupt status bits
// ****************************************************************
`define CIT_IRQ_LOW_MATCH 0
`define CIT_IRQ_HIGH_MATCH 1

// ****************************************************************
// prescaler taps: divide by 2, 8, 32, 128, 4096 (bit index of counter)
// ****************************************************************
`define CIT_PRE_W 12
`define CIT_TAP_DIV2 0
`define CIT_TAP_DIV8 2
`define CIT_TAP_DIV32 4
`define CIT_TAP_DIV128 6
`define CIT_TAP_DIV4096 11

`endif

// >>> rtl/cit_timer.v
// cascaded sixteen-bit interval timer with ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "cit_regs.vh"

module cit_timer (
  input wire sys_clk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output wire [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  input wire external_count_input_i,
  output wire square_wave_o,
  output wire irq_o
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [2:0] count_clock_select_low_r;
  reg [2:0] count_clock_select_high_r;
  reg [7:0] low_compare_byte_r;
  reg [7:0] high_compare_byte_r;
  reg [7:0] low_timer_mode_control_r;
  reg [7:0] high_timer_mode_control_r;
  reg [7:0] low_count_byte_r;
  reg [7:0] high_count_byte_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_en_r;
  reg [`CIT_PRE_W-1:0] pre_r;
  reg [`CIT_PRE_W-1:0] pre_prev_r;
  reg ext_prev_r;
  reg square_wave_r;
  reg [31:0] hrdata_r;
  reg wr_pend_r;
  reg rd_pend_r;
  reg [7:0] addr_r;

  wire [7:0] low_cnt_nxt;
  wire [7:0] high_cnt_nxt;
  wire cascade;
  wire low_en;
  wire high_en;
  wire low_tick;
  wire high_tick;
  wire low_ext;
  wire low_match;
  wire high_match;
  wire casc_match;
  wire ext_rise;
  wire addr_phase;

  // ****************************************************************
  // bus slave: address phase capture, zero wait states
  // ****************************************************************
  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = hrdata_r;

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= addr_phase & hwrite_i;
      rd_pend_r <= addr_phase & ~hwrite_i;
      addr_r <= haddr_i[7:0];
    end
  end

  // read mux; data registered at the address phase so it stands in the data phase
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      hrdata_r <= 32'h0000_0000;
    else if (addr_phase & ~hwrite_i)
    begin
      case (haddr_i[7:0])
        `CIT_CLK_SEL_LOW_ADDR: hrdata_r <= {29'h0, count_clock_select_low_r};
        `CIT_CLK_SEL_HIGH_ADDR: hrdata_r <= {29'h0, count_clock_select_high_r};
        `CIT_LOW_CMP_ADDR: hrdata_r <= {24'h0, low_compare_byte_r};
        `CIT_HIGH_CMP_ADDR: hrdata_r <= {24'h0, high_compare_byte_r};
        `CIT_LOW_MODE_ADDR: hrdata_r <= {24'h0, low_timer_mode_control_r};
        `CIT_HIGH_MODE_ADDR: hrdata_r <= {24'h0, high_timer_mode_control_r};
        `CIT_LOW_CNT_ADDR: hrdata_r <= {24'h0, low_count_byte_r};
        `CIT_HIGH_CNT_ADDR: hrdata_r <= {24'h0, high_count_byte_r};
        `CIT_IRQ_STAT_ADDR: hrdata_r <= {30'h0, irq_stat_r};
        `CIT_IRQ_EN_ADDR: hrdata_r <= {30'h0, irq_en_r};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // control register writes
  // ****************************************************************
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      count_clock_select_low_r <= `CIT_CLK_SEL_RST;
      count_clock_select_high_r <= `CIT_CLK_SEL_RST;
      low_compare_byte_r <= `CIT_CMP_RST;
      high_compare_byte_r <= `CIT_CMP_RST;
      low_timer_mode_control_r <= `CIT_MODE_RST;
      high_timer_mode_control_r <= `CIT_MODE_RST;
      irq_en_r <= 2'h0;
    end
    else if (wr_pend_r)
    begin
      case (addr_r)
        `CIT_CLK_SEL_LOW_ADDR: count_clock_select_low_r <= hwdata_i[2:0];
        `CIT_CLK_SEL_HIGH_ADDR: count_clock_select_high_r <= hwdata_i[2:0];
        `CIT_LOW_CMP_ADDR: low_compare_byte_r <= hwdata_i[7:0];
        `CIT_HIGH_CMP_ADDR: high_compare_byte_r <= hwdata_i[7:0];
        `CIT_LOW_MODE_ADDR: low_timer_mode_control_r <= hwdata_i[7:0];
        `CIT_HIGH_MODE_ADDR: high_timer_mode_control_r <= hwdata_i[7:0];
        `CIT_IRQ_EN_ADDR: irq_en_r <= hwdata_i[1:0];
        default: irq_en_r <= irq_en_r;
      endcase
    end
  end

  // ****************************************************************
  // prescaler and count clock selection
  // ****************************************************************
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      pre_r <= 12'h000;
      pre_prev_r <= 12'h000;
      ext_prev_r <= 1'b0;
    end
    else
    begin
      pre_r <= pre_r + 12'h001; // free running, start not aligned to it
      pre_prev_r <= pre_r;
      ext_prev_r <= external_count_input_i;
    end
  end

  assign ext_rise = external_count_input_i & ~ext_prev_r;
  assign cascade = high_timer_mode_control_r[`CIT_MODE_CASCADE];

  // tick for one select code: rising edge of a prescaler bit is a count pulse
  function sel_tick;
    input [2:0] sel;
    input [`CIT_PRE_W-1:0] cur;
    input [`CIT_PRE_W-1:0] prv;
    input ext;
    begin
      case (sel)
        3'h0, 3'h1: sel_tick = ext;
        3'h2: sel_tick = 1'b1;
        3'h3: sel_tick = cur[`CIT_TAP_DIV2] & ~prv[`CIT_TAP_DIV2];
        3'h4: sel_tick = cur[`CIT_TAP_DIV8] & ~prv[`CIT_TAP_DIV8];
        3'h5: sel_tick = cur[`CIT_TAP_DIV32] & ~prv[`CIT_TAP_DIV32];
        3'h6: sel_tick = cur[`CIT_TAP_DIV128] & ~prv[`CIT_TAP_DIV128];
        default: sel_tick = cur[`CIT_TAP_DIV4096] & ~prv[`CIT_TAP_DIV4096];
      endcase
    end
  endfunction

  // ****************************************************************
  // counters
  // ****************************************************************
  assign low_en = low_timer_mode_control_r[`CIT_MODE_CNT_EN];
  // in cascade only the low enable gates the pair
  assign high_en = cascade ? low_en : high_timer_mode_control_r[`CIT_MODE_CNT_EN];
  assign low_ext = count_clock_select_low_r[2:1] == 2'b00;
  assign low_tick = low_en & sel_tick(count_clock_select_low_r, pre_r, pre_prev_r, ext_rise);
  // cascade ignores the high clock select
  assign high_tick = cascade ? (low_tick & (low_count_byte_r == 8'hFF))
    : high_en & sel_tick(count_clock_select_high_r, pre_r, pre_prev_r, ext_rise);

  // match checked on count value; compare zero matches on each pulse
  assign casc_match = cascade & low_en & ({high_count_byte_r, low_count_byte_r}
    == {high_compare_byte_r, low_compare_byte_r});
  assign low_match = cascade ? casc_match
    : (low_en & (low_count_byte_r == low_compare_byte_r));
  assign high_match = high_en & (high_count_byte_r == high_compare_byte_r);

  // the pulse at compare clears; a lowered compare runs past, wraps, then matches
  assign low_cnt_nxt = ~low_tick ? low_count_byte_r
    : (low_match ? 8'h00 : low_count_byte_r + 8'h01);
  assign high_cnt_nxt = cascade ? ((casc_match & low_tick) ? 8'h00
    : (high_tick ? high_count_byte_r + 8'h01 : high_count_byte_r))
    : (~high_tick ? high_count_byte_r : (high_match ? 8'h00 : high_count_byte_r + 8'h01));

  // counter update; stopped counters clear so the next start begins at zero
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      low_count_byte_r <= 8'h00;
      high_count_byte_r <= 8'h00;
    end
    else
    begin
      low_count_byte_r <= low_en ? low_cnt_nxt : 8'h00;
      high_count_byte_r <= high_en ? high_cnt_nxt : 8'h00;
    end
  end

  // ****************************************************************
  // match events, match hold, interrupt status
  // ****************************************************************
  // the low pulse that leaves compare is the event, so its period is compare plus one
  reg high_match_d_r;
  wire low_ev;
  assign low_ev = low_match & low_tick;

  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      high_match_d_r <= 1'b0;
      irq_stat_r <= 2'h0;
    end
    else
    begin
      high_match_d_r <= high_match;
      // set wins over a clear in the same cycle
      irq_stat_r[`CIT_IRQ_LOW_MATCH] <= low_ev
        | (irq_stat_r[`CIT_IRQ_LOW_MATCH] & ~(wr_pend_r & (addr_r == `CIT_IRQ_CLR_ADDR)
        & hwdata_i[`CIT_IRQ_LOW_MATCH]));
      irq_stat_r[`CIT_IRQ_HIGH_MATCH] <= (high_match & ~high_match_d_r)
        | (irq_stat_r[`CIT_IRQ_HIGH_MATCH] & ~(wr_pend_r & (addr_r == `CIT_IRQ_CLR_ADDR)
        & hwdata_i[`CIT_IRQ_HIGH_MATCH]));
    end
  end

  assign irq_o = |(irq_stat_r & irq_en_r);

  // ****************************************************************
  // square wave output
  // ****************************************************************
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
      square_wave_r <= 1'b0;
    else if (wr_pend_r & (addr_r == `CIT_LOW_MODE_ADDR) & hwdata_i[`CIT_MODE_LVL_SET])
      square_wave_r <= 1'b1;
    else if (wr_pend_r & (addr_r == `CIT_LOW_MODE_ADDR) & hwdata_i[`CIT_MODE_LVL_RST])
      square_wave_r <= 1'b0;
    else if (low_ev & ~(cascade & low_ext))
      square_wave_r <= ~square_wave_r;
  end

  assign square_wave_o = square_wave_r & low_timer_mode_control_r[`CIT_MODE_OUT_EN];

endmodule // cit_timer
`default_nettype wire

// >>> bench/cit_timer_asserts.sv
// port checker for the cascaded interval timer
`timescale 1ns/1ps
`default_nettype none
`include "cit_regs.vh"
// ************
// checker
// ************
module cit_timer_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic external_count_input_i,
  input wire logic square_wave_o,
  input wire logic irq_o
);
  logic ph_w_r;
  logic [7:0] ph_a_r;
  logic [7:0] lcmp_r;
  logic [7:0] hcmp_r;
  logic [1:0] en_r;
  wire tk = hsel_i && hready_i && htrans_i[1];
  wire rd = tk && !hwrite_i && haddr_i[31:8] == 24'h0;
  wire [7:0] a8 = haddr_i[7:0];
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // shadow of the compare and interrupt enable registers written over the bus
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      ph_w_r <= 1'b0;
      ph_a_r <= 8'h00;
      lcmp_r <= 8'h00;
      hcmp_r <= 8'h00;
      en_r <= 2'h0;
    end
    else
    begin
      ph_w_r <= tk && hwrite_i && haddr_i[31:8] == 24'h0;
      ph_a_r <= a8;
      if (ph_w_r && ph_a_r == `CIT_LOW_CMP_ADDR)
        lcmp_r <= hwdata_i[7:0];
      if (ph_w_r && ph_a_r == `CIT_HIGH_CMP_ADDR)
        hcmp_r <= hwdata_i[7:0];
      if (ph_w_r && ph_a_r == `CIT_IRQ_EN_ADDR)
        en_r <= hwdata_i[1:0];
    end
  end
  chk_resp_okay: assert property (hresp_o == 1'b0)
    else $error("error response seen");
  chk_ready_high: assert property (hreadyout_o == 1'b1)
    else $error("wait state seen");
  chk_reset_quiet: assert property ($past(rst_i) |-> !irq_o && !square_wave_o && hrdata_o == 32'h0)
    else $error("outputs not quiet after reset");
  chk_unmapped_zero: assert property (rd && a8 > 8'h28 |=> hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_enable_echo: assert property (rd && a8 == `CIT_IRQ_EN_ADDR |=> hrdata_o == {30'h0, en_r})
    else $error("enable readback wrong");
  chk_low_cmp_echo: assert property (
    rd && a8 == `CIT_LOW_CMP_ADDR |=> hrdata_o == {24'h0, lcmp_r})
    else $error("low compare readback wrong");
  chk_high_cmp_echo: assert property (
    rd && a8 == `CIT_HIGH_CMP_ADDR |=> hrdata_o == {24'h0, hcmp_r})
    else $error("high compare readback wrong");
  chk_irq_masked: assert property (irq_o |-> en_r != 2'h0)
    else $error("interrupt with all sources masked");
  cover property ($rose(irq_o));
  cover property ($rose(square_wave_o));
  cover property (rd && a8 == `CIT_IRQ_STAT_ADDR ##1 hrdata_o[0]);
endmodule // cit_timer_chk

bind cit_timer cit_timer_chk i_cit_timer_chk (.sys_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
  .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o,
  .external_count_input_i, .square_wave_o, .irq_o);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the cascaded interval timer
`timescale 1ns/1ps
`default_nettype none
`include "cit_regs.vh"
// ************
// bench
// ************
module testbench;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic hwrite_i = 1'b0;
  logic external_count_input_i = 1'b0;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o, rv;
  logic hreadyout_o, hresp_o, square_wave_o, irq_o, sq;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  int divs[6] = '{1, 2, 8, 32, 128, 4096};
  cit_timer i_cit_timer (.sys_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .external_count_input_i, .square_wave_o, .irq_o);
  // clock and cycle count
  initial forever #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one single ahb-lite transfer, read data into rv
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {24'h0, a};
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge sys_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge sys_clk_i);
    rv = hrdata_o;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic wirq;
    @(posedge sys_clk_i);
    while (irq_o !== 1'b1) @(posedge sys_clk_i);
  endtask
  task automatic pulse;
    repeat (2) @(posedge sys_clk_i);
    external_count_input_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    external_count_input_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  // hang guard
  initial
  begin
    #480000;
    miscompares++;
    final_report;
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a <= 'h30; a += 4) rdc(a[7:0], 32'h0);
    bus(1'b1, `CIT_LOW_CMP_ADDR, 32'h1A5);
    rdc(`CIT_LOW_CMP_ADDR, 32'hA5);
    bus(1'b1, `CIT_HIGH_CMP_ADDR, 32'hFF);
    rdc(`CIT_HIGH_CMP_ADDR, 32'hFF);
    bus(1'b1, `CIT_HIGH_CMP_ADDR, 32'h01);
    bus(1'b1, `CIT_LOW_CMP_ADDR, 32'h03);
    bus(1'b1, `CIT_CLK_SEL_LOW_ADDR, 32'h2);
    bus(1'b1, `CIT_CLK_SEL_HIGH_ADDR, 32'h1);
    bus(1'b1, `CIT_IRQ_EN_ADDR, 32'h1);
    bus(1'b1, `CIT_HIGH_MODE_ADDR, 32'h90);
    bus(1'b1, `CIT_LOW_MODE_ADDR, 32'h81);
    wirq;
    t0 = cyc;
    sq = square_wave_o;
    rdc(`CIT_IRQ_STAT_ADDR, 32'h3);
    bus(1'b1, `CIT_IRQ_CLR_ADDR, 32'h3);
    wirq;
    chk(32'(cyc - t0), 32'd260);
    chk({31'h0, square_wave_o}, {31'h0, ~sq});
    // stopping by the low enable alone halts and zeroes the count
    bus(1'b1, `CIT_LOW_MODE_ADDR, 32'h0);
    bus(1'b1, `CIT_IRQ_CLR_ADDR, 32'h3);
    repeat (600) @(posedge sys_clk_i);
    rdc(`CIT_IRQ_STAT_ADDR, 32'h0);
    rdc(`CIT_LOW_CNT_ADDR, 32'h0);
    // every internal clock code, high select left on an idle input
    bus(1'b1, `CIT_HIGH_CMP_ADDR, 32'h0);
    bus(1'b1, `CIT_LOW_CMP_ADDR, 32'h7);
    for (int c = 2; c < 8; c++)
    begin
      bus(1'b1, `CIT_LOW_MODE_ADDR, 32'h0);
      bus(1'b1, `CIT_CLK_SEL_LOW_ADDR, 32'(c));
      bus(1'b1, `CIT_IRQ_CLR_ADDR, 32'h3);
      bus(1'b1, `CIT_LOW_MODE_ADDR, 32'h80);
      wirq;
      t0 = cyc;
      bus(1'b1, `CIT_IRQ_CLR_ADDR, 32'h3);
      wirq;
      chk(32'(cyc - t0), 32'(8 * divs[c - 2]));
    end
    // external codes with compare zero
    bus(1'b1, `CIT_LOW_CMP_ADDR, 32'h0);
    for (int c = 0; c < 2; c++)
    begin
      bus(1'b1, `CIT_LOW_MODE_ADDR, 32'h0);
      bus(1'b1, `CIT_CLK_SEL_LOW_ADDR, 32'(c));
      bus(1'b1, `CIT_IRQ_CLR_ADDR, 32'h3);
      bus(1'b1, `CIT_LOW_MODE_ADDR, 32'h81);
      sq = square_wave_o;
      pulse;
      bus(1'b0, `CIT_IRQ_STAT_ADDR, 32'h0);
      chk({31'h0, rv[0]}, 32'h1);
      chk({31'h0, square_wave_o}, {31'h0, sq});
      bus(1'b1, `CIT_LOW_MODE_ADDR, 32'h0);
      bus(1'b1, `CIT_IRQ_CLR_ADDR, 32'h3);
      pulse;
      bus(1'b0, `CIT_IRQ_STAT_ADDR, 32'h0);
      chk({31'h0, rv[0]}, 32'h0);
    end
    final_report;
  end
endmodule // testbench
`default_nettype wire
